// [core_model.sv]
// behavioural cpu core: accepts offered vectors and returns from them
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic vector_req,
    input  wire logic slow,
    input  wire logic use_return_from_irq,
    output logic      vector_taken,
    output logic      return_from_irq
);
    logic [1:0] phase_r;
    logic [3:0] wait_r;
    // slow mode leaves the offer standing for several cycles before acceptance
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            phase_r         <= 2'h0;
            wait_r          <= 4'h0;
            vector_taken    <= 1'b0;
            return_from_irq <= 1'b0;
        end else begin
            vector_taken    <= 1'b0;
            return_from_irq <= 1'b0;
            if (wait_r != 4'h0) begin
                wait_r <= wait_r - 4'h1;
            end else if (phase_r == 2'h0 && vector_req) begin
                phase_r <= 2'h1;
                wait_r  <= slow ? 4'h6 : 4'h0;
            end else if (phase_r == 2'h1) begin
                vector_taken <= 1'b1;
                phase_r      <= 2'h2;
                wait_r       <= 4'h4;
            end else if (phase_r == 2'h2) begin
                return_from_irq <= use_return_from_irq;
                phase_r         <= 2'h0;
            end
        end
    end
endmodule : core_model
`default_nettype wire

// [irq_tb_pkg.sv]
// types for the interrupt and time base block
package irq_tb_pkg;
    typedef enum logic [2:0] {
        IDLE_ST = 3'b001,
        CALL_ST = 3'b010,
        WAIT_ST = 3'b100
    } vec_state_t;
    typedef logic [8:0] src_vec_t;
endpackage : irq_tb_pkg

// [irq_tb_regs.svh]
// register map, field positions and field codes for the interrupt and time base block
`ifndef IRQ_TB_REGS_SVH
`define IRQ_TB_REGS_SVH

`define OFS_PRESCALER      8'h00
`define OFS_TICK0_CTRL     8'h04
`define OFS_TICK1_CTRL     8'h08
`define OFS_EDGE_SELECT    8'h0C
`define OFS_IRQ_ENABLE     8'h10
`define OFS_IRQ_FLAGS      8'h14
`define OFS_CORE_CTRL      8'h18
`define OFS_PIN_CTRL       8'h1C

`define NUM_SRC            9
`define SRC_PIN_A          0
`define SRC_PIN_B          1
`define SRC_AMP            2
`define SRC_SER_A          3
`define SRC_SER_B          4
`define SRC_TICK0          5
`define SRC_TICK1          6
`define SRC_CONV           7
`define SRC_UART           8

`define TICK_RUN_BIT       7
`define TICK_CODE_W        3
`define TICK_BASE_EXP      8
`define TICK_CNT_W         15
`define CORE_GIE_BIT       0
`define CORE_STACK_BIT     1

`define EDGE_OFF           2'h0
`define EDGE_RISE          2'h1
`define EDGE_FALL          2'h2
`define EDGE_BOTH          2'h3

`define PSC_SYS            2'h0
`define PSC_SYS_DIV4       2'h1
`define PSC_DIV4_CNT       2'h3

`endif

// [irq_time_base.sv]
// interrupt request, vectoring and time base logic with an axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "irq_tb_regs.svh"
module irq_time_base (
    input  wire logic                 clock,
    input  wire logic                 rstn,
    // axi4-lite slave
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // pins and peripheral events
    input  wire logic                 ext_irq_pin_a,
    input  wire logic                 ext_irq_pin_b,
    input  wire logic                 amp_output_ready,
    input  wire logic                 serial_a_event,
    input  wire logic                 serial_b_event,
    input  wire logic                 conv_done_event,
    input  wire logic                 uart_irq_pulse,
    input  wire logic                 sub_clock_tick,
    // cpu core side
    input  wire logic                 stack_full,
    input  wire logic                 vector_taken,
    input  wire logic                 return_from_irq,
    output logic                      vector_req,
    output irq_tb_pkg::src_vec_t      vector_sel,
    output logic                      wake_up,
    output logic                      global_irq_enable,
    output logic [1:0]                pin_pullup_en
);
    import irq_tb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    logic [1:0]                   prescaler_source_code_r;
    logic [7:0]                   tick0_ctrl_r;
    logic [7:0]                   tick1_ctrl_r;
    logic [3:0]                   edge_select_reg_r;
    src_vec_t                     enables_r;
    src_vec_t                     flags_r;
    src_vec_t                     flags_nxt;
    logic                         gie_r;
    logic [5:0]                   pin_ctrl_r;
    vec_state_t                   state_r;
    src_vec_t                     sel_r;

    // pin_ctrl: [1:0] function select, [3:2] direction input, [5:4] pull-up
    wire [1:0] pin_fn_sel = pin_ctrl_r[1:0];
    wire [1:0] pin_dir_in = pin_ctrl_r[3:2];

    ////////////////////////////////////////////////////////////////////////////////
    // synchronisers for pins and asynchronous status
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [3:0] prev_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
            prev_r  <= 4'h0;
        end else begin
            sync1_r <= {sub_clock_tick, amp_output_ready, ext_irq_pin_b, ext_irq_pin_a};
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    function automatic logic edge_hit(input logic [1:0] mode, input logic cur, input logic old);
        logic rise;
        logic fall;
        rise = cur & ~old;
        fall = ~cur & old;
        case (mode)
            `EDGE_RISE: edge_hit = rise;
            `EDGE_FALL: edge_hit = fall;
            `EDGE_BOTH: edge_hit = rise | fall;
            default:    edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    // pin counts only when enabled, routed and an input
    wire pin_a_live = enables_r[`SRC_PIN_A] & pin_fn_sel[0] & pin_dir_in[0];
    wire pin_b_live = enables_r[`SRC_PIN_B] & pin_fn_sel[1] & pin_dir_in[1];
    wire pin_a_ev = pin_a_live & edge_hit(edge_select_reg_r[1:0], sync2_r[0], prev_r[0]);
    wire pin_b_ev = pin_b_live & edge_hit(edge_select_reg_r[3:2], sync2_r[1], prev_r[1]);
    wire amp_ev   = sync2_r[2] & ~prev_r[2];
    wire sub_tick = sync2_r[3] & ~prev_r[3];

    ////////////////////////////////////////////////////////////////////////////////
    // prescaler clock enable
    logic [1:0] div4_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) div4_r <= 2'h0;
        else       div4_r <= div4_r + 2'h1;
    end
    wire div4_tick = (div4_r == `PSC_DIV4_CNT);
    wire psc_tick  = (prescaler_source_code_r == `PSC_SYS)      ? 1'b1 :
                     (prescaler_source_code_r == `PSC_SYS_DIV4) ? div4_tick : sub_tick;

    // time base dividers, overflow after 2^(8+code) prescaler cycles
    function automatic logic tick_ovf(input logic [`TICK_CNT_W-1:0] cnt,
                                      input logic [2:0] code);
        logic [`TICK_CNT_W-1:0] last;
        last = {`TICK_CNT_W{1'b1}} >> (3'h7 - code);
        tick_ovf = (cnt == last);
    endfunction : tick_ovf

    logic [`TICK_CNT_W-1:0] tick0_cnt_r;
    logic [`TICK_CNT_W-1:0] tick1_cnt_r;
    wire tick0_run = tick0_ctrl_r[`TICK_RUN_BIT];
    wire tick1_run = tick1_ctrl_r[`TICK_RUN_BIT];
    wire tick0_ev  = tick0_run & psc_tick & tick_ovf(tick0_cnt_r, tick0_ctrl_r[2:0]);
    wire tick1_ev  = tick1_run & psc_tick & tick_ovf(tick1_cnt_r, tick1_ctrl_r[2:0]);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tick0_cnt_r <= '0;
            tick1_cnt_r <= '0;
        end else begin
            // stopped generators restart from zero so the first period is whole
            if (!tick0_run) tick0_cnt_r <= '0;
            else if (psc_tick) tick0_cnt_r <= tick0_ev ? '0 : tick0_cnt_r + 1'b1;
            if (!tick1_run) tick1_cnt_r <= '0;
            else if (psc_tick) tick1_cnt_r <= tick1_ev ? '0 : tick1_cnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave; one write and one read at a time
    logic       aw_held_r;
    logic       w_held_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    wire aw_take  = s_axi_awvalid & s_axi_awready;
    wire w_take   = s_axi_wvalid & s_axi_wready;
    wire have_aw  = aw_held_r | aw_take;
    wire have_w   = w_held_r | w_take;
    wire [7:0]  wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
    wire [31:0] wr_data = w_held_r ? wdata_r : s_axi_wdata;
    wire        wr_lo   = w_held_r ? wstrb_r[0] : s_axi_wstrb[0];
    wire        wr_lo2  = w_held_r ? wstrb_r[1] : s_axi_wstrb[1];
    wire do_write = have_aw & have_w & ~s_axi_bvalid;
    wire wr_ok    = (wr_addr[7:5] == 3'h0) & (wr_addr[1:0] == 2'h0);
    wire wr_en    = do_write & wr_ok & wr_lo;
    wire [7:0] wr_byte = wr_data[7:0];
    wire sel_psc   = wr_en & (wr_addr == `OFS_PRESCALER);
    wire sel_t0    = wr_en & (wr_addr == `OFS_TICK0_CTRL);
    wire sel_t1    = wr_en & (wr_addr == `OFS_TICK1_CTRL);
    wire sel_edge  = wr_en & (wr_addr == `OFS_EDGE_SELECT);
    wire sel_en    = wr_en & (wr_addr == `OFS_IRQ_ENABLE);
    wire sel_flag  = wr_en & (wr_addr == `OFS_IRQ_FLAGS);
    wire sel_core  = wr_en & (wr_addr == `OFS_CORE_CTRL);
    wire sel_pin   = wr_en & (wr_addr == `OFS_PIN_CTRL);
    wire [8:0] wr_nine = {wr_lo2 ? wr_data[8] : 1'b0, wr_byte};

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            awaddr_r      <= 8'h00;
            wdata_r       <= 32'h0000_0000;
            wstrb_r       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            if (aw_take) begin
                aw_held_r <= ~do_write;
                awaddr_r  <= s_axi_awaddr;
            end else if (do_write) aw_held_r <= 1'b0;
            if (w_take) begin
                w_held_r <= ~do_write;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end else if (do_write) w_held_r <= 1'b0;
            s_axi_awready <= ~have_aw & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready  <= ~have_w & ~s_axi_wready & ~s_axi_bvalid;
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
        end
    end

    wire [7:0] rd_addr = s_axi_araddr;
    wire rd_ok = (rd_addr[7:5] == 3'h0) & (rd_addr[1:0] == 2'h0);
    wire [31:0] rd_mux =
        (rd_addr == `OFS_PRESCALER)   ? {30'h0, prescaler_source_code_r} :
        (rd_addr == `OFS_TICK0_CTRL)  ? {24'h0, tick0_ctrl_r} :
        (rd_addr == `OFS_TICK1_CTRL)  ? {24'h0, tick1_ctrl_r} :
        (rd_addr == `OFS_EDGE_SELECT) ? {28'h0, edge_select_reg_r} :
        (rd_addr == `OFS_IRQ_ENABLE)  ? {23'h0, enables_r} :
        (rd_addr == `OFS_IRQ_FLAGS)   ? {23'h0, flags_r} :
        (rd_addr == `OFS_CORE_CTRL)   ? {30'h0, stack_full, gie_r} :
        (rd_addr == `OFS_PIN_CTRL)    ? {26'h0, pin_ctrl_r} : 32'h0000_0000;
    wire ar_take = s_axi_arvalid & s_axi_arready;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_ok ? rd_mux : 32'h0000_0000;
                s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
            end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // request flags and vectoring
    wire [8:0] events = {uart_irq_pulse, conv_done_event, tick1_ev, tick0_ev,
                         serial_b_event, serial_a_event, amp_ev, pin_b_ev, pin_a_ev};
    wire [8:0] ready_req = flags_r & enables_r;
    wire [8:0] pick = ready_req & (~ready_req + 9'h001);
    wire       can_call = gie_r & ~stack_full & (ready_req != 9'h000);
    wire [8:0] svc_clr = (state_r == CALL_ST && vector_taken) ? sel_r : 9'h000;

    always_comb begin
        flags_nxt = flags_r;
        if (sel_flag) flags_nxt = flags_r & ~wr_nine; // write one to clear
        flags_nxt = (flags_nxt & ~svc_clr) | events;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prescaler_source_code_r <= 2'h0;
            tick0_ctrl_r            <= 8'h00;
            tick1_ctrl_r            <= 8'h00;
            edge_select_reg_r       <= 4'h0;
            enables_r               <= 9'h000;
            pin_ctrl_r              <= 6'h00;
            flags_r                 <= 9'h000;
        end else begin
            if (sel_psc)  prescaler_source_code_r <= wr_byte[1:0];
            if (sel_t0)   tick0_ctrl_r <= wr_byte & 8'h87;
            if (sel_t1)   tick1_ctrl_r <= wr_byte & 8'h87;
            if (sel_edge) edge_select_reg_r <= wr_byte[3:0];
            if (sel_en)   enables_r <= wr_nine;
            if (sel_pin)  pin_ctrl_r <= wr_byte[5:0];
            flags_r <= flags_nxt;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= IDLE_ST;
            sel_r   <= 9'h000;
            gie_r   <= 1'b0;
        end else begin
            case (state_r)
                IDLE_ST: begin
                    if (can_call) begin
                        state_r <= CALL_ST;
                        sel_r   <= pick;
                    end
                end
                CALL_ST: begin
                    if (vector_taken) begin
                        state_r <= WAIT_ST;
                        gie_r   <= 1'b0;
                    end
                end
                WAIT_ST: state_r <= IDLE_ST;
                default: state_r <= IDLE_ST;
            endcase
            if (sel_core) gie_r <= wr_byte[`CORE_GIE_BIT];
            else if (return_from_irq) gie_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            vector_req        <= 1'b0;
            vector_sel        <= 9'h000;
            wake_up           <= 1'b0;
            global_irq_enable <= 1'b0;
            pin_pullup_en     <= 2'h0;
        end else begin
            // the offer stands until the core takes it, so a busy core cannot miss it
            vector_req        <= ((state_r == IDLE_ST) & can_call) |
                                 ((state_r == CALL_ST) & ~vector_taken);
            vector_sel        <= (state_r == IDLE_ST && can_call) ? pick : vector_sel;
            wake_up           <= |(flags_nxt & ~flags_r);
            global_irq_enable <= gie_r;
            pin_pullup_en     <= pin_ctrl_r[5:4];
        end
    end
endmodule : irq_time_base
`default_nettype wire

// [irq_time_base_asserts.sv]
// assertions on vectoring, wake-up and global enable of the interrupt block
`timescale 1ns/1ps
`default_nettype none
module irq_time_base_chk (
    input wire logic                 clock,
    input wire logic                 rstn,
    input wire logic                 stack_full,
    input wire logic                 vector_taken,
    input wire logic                 return_from_irq,
    input wire logic                 vector_req,
    input wire irq_tb_pkg::src_vec_t vector_sel,
    input wire logic                 wake_up,
    input wire logic                 global_irq_enable
);
    import irq_tb_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    property p_stk; $rose(vector_req) |-> !$past(stack_full); endproperty
    a_stk: assert property (p_stk) else $error("call raised with stack full");
    // the enable output may lag the internal bit by one cycle
    property p_gie;
        $rose(vector_req) |-> global_irq_enable || $past(global_irq_enable);
    endproperty
    a_gie: assert property (p_gie) else $error("call raised with global off");
    property p_one; vector_req |-> $onehot(vector_sel); endproperty
    a_one: assert property (p_one) else $error("offered source not one-hot");
    property p_hold; vector_req && !vector_taken |=> vector_req && $stable(vector_sel); endproperty
    a_hold: assert property (p_hold) else $error("offer withdrawn or changed");
    property p_drop; vector_req && vector_taken |=> !vector_req; endproperty
    a_drop: assert property (p_drop) else $error("offer kept after acceptance");
    property p_off; vector_req && vector_taken |-> ##[1:3] !global_irq_enable; endproperty
    a_off: assert property (p_off) else $error("global enable kept after service");
    property p_return_from_irq; return_from_irq |-> ##[1:3] global_irq_enable; endproperty
    a_return_from_irq: assert property (p_return_from_irq) else $error("global enable not restored");
    property p_wake; wake_up |=> !wake_up; endproperty
    a_wake: assert property (p_wake) else $error("wake pulse too long");
    c_uart: cover property (vector_taken && vector_sel == 9'h100);
    c_wake: cover property (wake_up);
    c_return_from_irq: cover property (return_from_irq);
endmodule : irq_time_base_chk
bind irq_time_base irq_time_base_chk i_chk (.clock, .rstn, .stack_full, .vector_taken,
    .return_from_irq, .vector_req, .vector_sel, .wake_up, .global_irq_enable);
`default_nettype wire

// [peripheral_interrupt_and_time_base_test.sv]
// self-checking bench for the interrupt and time base block
`timescale 1ns/1ps
`default_nettype none
module peripheral_interrupt_and_time_base_test;
    import irq_tb_pkg::*;
    logic        clock = 0, rstn = 0, stack_full = 0, slow = 0, use_return_from_irq = 1;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, q;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, ext_irq_pin_a = 0, amp_output_ready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, pin_pullup_en, r;
    logic [3:0]  ev = '0;
    logic        sub_clk = 0;
    logic        vector_taken, return_from_irq, vector_req, wake_up, global_irq_enable;
    src_vec_t    vector_sel;
    src_vec_t    sq[$];
    src_vec_t    ex[4] = '{9'h008, 9'h010, 9'h080, 9'h100};
    int          tq[$];
    int          fail_count = 0, tests_run = 0, cyc = 0, wk = 0;

    always #12.5 clock = ~clock;
    // sub clock at half the system rate: one prescaler tick every two cycles
    always @(posedge clock) sub_clk <= ~sub_clk;

    irq_time_base i_irq_time_base (.clock, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_irq_pin_a,
        .ext_irq_pin_b(ext_irq_pin_a), .amp_output_ready, .serial_a_event(ev[0]),
        .serial_b_event(ev[1]), .conv_done_event(ev[2]), .uart_irq_pulse(ev[3]),
        .sub_clock_tick(sub_clk), .stack_full, .vector_taken, .return_from_irq, .vector_req,
        .vector_sel, .wake_up, .global_irq_enable, .pin_pullup_en);
    core_model i_core_model (.clock, .rstn, .vector_req, .slow, .use_return_from_irq, .vector_taken,
        .return_from_irq);

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (wake_up === 1'b1) wk <= wk + 1;
        if (vector_taken === 1'b1) begin
            sq.push_back(vector_sel);
            tq.push_back(cyc);
        end
    end

    ////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one access; valids drop on their own ready, the answer ends it
    task automatic acc(input bit w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rq, output logic [1:0] rr);
        bit done;
        done = 0;
        @(posedge clock);
        if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        while (!done) begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid) begin
                done = 1;
                s_axi_bready <= 1'b0;
                rr = s_axi_bresp;
                rq = '0;
            end
            if (s_axi_rready && s_axi_rvalid) begin
                done = 1;
                s_axi_rready <= 1'b0;
                rr = s_axi_rresp;
                rq = s_axi_rdata;
            end
        end
    endtask : acc

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d, q, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        acc(1'b0, a, 32'h0, q, r);
        chk(nm, q, exp);
    endtask : rd

    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask : wt

    task automatic pulse(input logic [3:0] e);
        @(posedge clock);
        ev <= e;
        @(posedge clock);
        ev <= 4'h0;
    endtask : pulse

    task automatic takes(input int n);
        while (sq.size() < n) @(posedge clock);
    endtask : takes

    // distance between two later services gives the divider period
    task automatic period(input logic [1:0] psc, input logic [7:0] ofs, input logic [2:0] code,
                          input int exp);
        wr(8'h00, {30'h0, psc});
        sq.delete();
        tq.delete();
        wr(ofs, {24'h0, 5'h10, code});
        takes(3);
        wr(ofs, 32'h0);
        chk("period", tq[2] - tq[1], exp);
    endtask : period

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        for (int a = 0; a < 32; a += 4) rd(a[7:0], 32'h0, "reset value");
        acc(1'b0, 8'h20, 32'h0, q, r);
        chk("unmapped read", {q[29:0], r}, 32'h2);
        acc(1'b1, 8'h24, 32'hFF, q, r);
        chk("unmapped write", r, 32'h2);
        wr(8'h00, 32'hFF);
        rd(8'h00, 32'h3, "prescaler");
        wr(8'h04, 32'hFF);
        rd(8'h04, 32'h87, "tick0 ctrl");
        wr(8'h08, 32'h7F);
        rd(8'h08, 32'h07, "tick1 ctrl");
        wr(8'h04, 32'h0);
        wr(8'h14, 32'h1FF);
        pulse(4'h1);
        wt(3);
        chk("wake", wk, 1);
        pulse(4'h1);
        wt(3);
        chk("wake again", wk, 1);
        amp_output_ready <= 1'b1;
        wt(8);
        rd(8'h14, 32'h00C, "flags");
        chk("wake amp", wk, 2);
        chk("no call", sq.size(), 0);
        wr(8'h14, 32'h1FF);
        wr(8'h10, 32'h198);
        wr(8'h18, 32'h1);
        slow <= 1'b1;
        pulse(4'hF);
        takes(4);
        wt(10);
        for (int i = 0; i < 4; i++) chk("order", sq[i], ex[i]);
        rd(8'h14, 32'h0, "flags serviced");
        rd(8'h18, 32'h1, "global restored");
        slow <= 1'b0;
        stack_full <= 1'b1;
        pulse(4'h4);
        wt(20);
        chk("held by stack", sq.size(), 4);
        rd(8'h18, 32'h3, "core ctrl");
        stack_full <= 1'b0;
        takes(5);
        chk("call after stack", sq[4], 9'h080);
        wt(10);
        wr(8'h10, 32'h060);
        period(2'h0, 8'h04, 3'h0, 256);
        period(2'h0, 8'h08, 3'h2, 1024);
        period(2'h1, 8'h04, 3'h1, 2048);
        period(2'h2, 8'h04, 3'h0, 512);
        wr(8'h14, 32'h1FF);
        wr(8'h10, 32'h180);
        use_return_from_irq <= 1'b0;
        sq.delete();
        pulse(4'h4);
        takes(1);
        wt(10);
        rd(8'h18, 32'h0, "plain return");
        pulse(4'h8);
        wt(20);
        chk("global off", sq.size(), 1);
        rd(8'h14, 32'h100, "flag kept");
        wr(8'h10, 32'h003);
        wr(8'h1C, 32'h2F);
        wt(1);
        chk("pull-up", pin_pullup_en, 2'h2);
        for (int m = 0; m < 4; m++) begin
            wr(8'h0C, m);
            wr(8'h14, 32'h1FF);
            ext_irq_pin_a <= 1'b1;
            wt(6);
            rd(8'h14, {31'h0, m[0]}, "pin rise");
            ext_irq_pin_a <= 1'b0;
            wt(6);
            rd(8'h14, {31'h0, m[0] | m[1]}, "pin fall");
        end
        wr(8'h1C, 32'h23);
        wr(8'h14, 32'h1FF);
        ext_irq_pin_a <= 1'b1;
        wt(6);
        rd(8'h14, 32'h0, "pin not input");
        chk("pull-up kept", pin_pullup_en, 2'h2);
        close_out();
    end

    // the whole sequence needs about twelve thousand cycles
    initial begin
        repeat (40000) @(posedge clock);
        fail_count++;
        close_out();
    end
endmodule : peripheral_interrupt_and_time_base_test
`default_nettype wire
